// ==== pkg/smbcs_pkg.sv ====
// Constants, types and register map of the SMBus control and status flag block
// Functional notes
// - Master flag set on generated START, cleared on generated STOP or lost arbitration.
// - Transmit flag set on generated START or data written before a frame.
// - Transmit flag cleared on detected START, lost arbitration, or unwritten data.
// - Start flag set on received START plus address byte; only software clears it.
// - Stop flag set when STOP is detected while addressed as slave.
// - Stop flag set when arbitration is lost to a detected STOP.
// - Stop flag cleared once the requested STOP has been driven.
// - Ack request set after a received byte needing a software acknowledge value.
// - Ack request cleared after every acknowledge cycle.
// - Arbitration lost on unwanted repeated START seen as master with start low.
// - Arbitration lost when SCL is low while making STOP or repeated START.
// - Arbitration lost when SDA reads low while sending a one, outside acks.
// - Arbitration lost flag cleared each time software clears the byte event flag.
// - Transmitter loads ack bit: one for low response, zero for high.
// - Byte event set when START is generated and when arbitration is lost.
// - Byte event set after byte sent with ack sampled, and after byte received.
// - Byte event set on received START plus address, and on received STOP while addressed as slave.
// - Receiver event comes before ack cycle, transmitter event after it.
// - Master, transmit, start and stop flags form the upper four control bits.
`default_nettype none
package smbcs_pkg;
  localparam int          DW           = 32;
  localparam logic [31:0] OFF_CTRL     = 32'h0000_0000;
  localparam logic [31:0] OFF_DATA     = 32'h0000_0004;
  localparam logic [31:0] OFF_OWN      = 32'h0000_0008;
  localparam int          B_SI         = 0;
  localparam int          B_ACK        = 1;
  localparam int          B_START      = 5;
  localparam int          B_STOP       = 4;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  DATA_RST     = 8'h00;
  localparam logic [6:0]  OWN_RST      = 7'h00;
  localparam int          CLK_MHZ      = 125;
  localparam int          T_HALF_NS    = 1250;
  localparam int          HALF_CYC     = (T_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  HALF_LOAD    = 8'(HALF_CYC - 1);
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam logic [1:0]  PH_0         = 2'h0;
  localparam logic [1:0]  PH_1         = 2'h1;
  localparam logic [1:0]  PH_2         = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_GSTART = 6'h02,
    ST_BYTE   = 6'h04,
    ST_ACK    = 6'h08,
    ST_GSTOP  = 6'h10,
    ST_GRST   = 6'h20
  } smbcs_state_t;
endpackage : smbcs_pkg
`default_nettype wire

// ==== pkg/smbcs_line_if.sv ====
// Synchronised line levels and bus events passed to the flag engine
`default_nettype none
interface smbcs_line_if;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport src (output scl_s, output sda_s, output scl_rise, output scl_fall, output start_det, output stop_det);
  modport dst (input scl_s, input sda_s, input scl_rise, input scl_fall, input start_det, input stop_det);
endinterface : smbcs_line_if
`default_nettype wire

// ==== src/smbcs_line_mon.sv ====
// Line synchroniser and START, STOP and SCL edge detector
`default_nettype none
module smbcs_line_mon (
  input  wire logic  i_mclk,
  input  wire logic  i_srst,
  input  wire logic  i_scl,
  input  wire logic  i_sda,
  smbcs_line_if.src  lines
);
  import smbcs_pkg::*;

  logic [1:0] scl_m_reg, scl_m_next;
  logic [1:0] sda_m_reg, sda_m_next;
  logic [1:0] scl_h_reg, scl_h_next;
  logic [1:0] sda_h_reg, sda_h_next;
  logic [3:0] ev_reg,    ev_next;

  // First stage feeds only the second; history taps start after it
  always_comb begin
    scl_m_next = {scl_m_reg[0], i_scl};
    sda_m_next = {sda_m_reg[0], i_sda};
    scl_h_next = {scl_h_reg[0], scl_m_reg[1]};
    sda_h_next = {sda_h_reg[0], sda_m_reg[1]};
    ev_next[0] = scl_h_reg[0] & ~scl_h_reg[1];
    ev_next[1] = ~scl_h_reg[0] & scl_h_reg[1];
    ev_next[2] = scl_h_reg[0] & scl_h_reg[1] & ~sda_h_reg[0] & sda_h_reg[1];
    ev_next[3] = scl_h_reg[0] & scl_h_reg[1] & sda_h_reg[0] & ~sda_h_reg[1];
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      scl_m_reg <= 2'h3;
      sda_m_reg <= 2'h3;
      scl_h_reg <= 2'h3;
      sda_h_reg <= 2'h3;
      ev_reg    <= 4'h0;
    end else begin
      scl_m_reg <= scl_m_next;
      sda_m_reg <= sda_m_next;
      scl_h_reg <= scl_h_next;
      sda_h_reg <= sda_h_next;
      ev_reg    <= ev_next;
    end
  end

  assign lines.scl_s     = scl_h_reg[1];
  assign lines.sda_s     = sda_h_reg[1];
  assign lines.scl_rise  = ev_reg[0];
  assign lines.scl_fall  = ev_reg[1];
  assign lines.start_det = ev_reg[2];
  assign lines.stop_det  = ev_reg[3];
endmodule : smbcs_line_mon
`default_nettype wire

// ==== src/smbcs_top.sv ====
// SMBus control and status flag engine with AHB-Lite register slave
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`default_nettype none
module smbcs_top (
  input  wire logic                     i_mclk,
  input  wire logic                     i_srst,
  input  wire logic                     i_hsel,
  input  wire logic [smbcs_pkg::DW-1:0] i_haddr,
  input  wire logic [1:0]               i_htrans,
  input  wire logic                     i_hwrite,
  input  wire logic [2:0]               i_hsize,
  input  wire logic [smbcs_pkg::DW-1:0] i_hwdata,
  input  wire logic                     i_hready,
  output logic      [smbcs_pkg::DW-1:0] o_hrdata,
  output logic                          o_hreadyout,
  output logic                          o_hresp,
  input  wire logic                     i_scl,
  output logic                          o_scl_out,
  output logic                          o_scl_oe,
  input  wire logic                     i_sda,
  output logic                          o_sda_out,
  output logic                          o_sda_oe
);
  import smbcs_pkg::*;

  function automatic logic f_hit(input logic [DW-1:0] addr, input logic [DW-1:0] off);
    f_hit = (addr[DW-1:2] == off[DW-1:2]);
  endfunction : f_hit

  smbcs_line_if lines ();

  smbcs_line_mon u_mon (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .i_scl  (i_scl),
    .i_sda  (i_sda),
    .lines  (lines)
  );

  smbcs_state_t    state_reg,   state_next;
  logic [1:0]      phase_reg,   phase_next;
  logic [7:0]      timer_reg,   timer_next;
  logic [3:0]      cnt_reg,     cnt_next;
  logic [7:0]      shift_reg,   shift_next;
  logic [6:0]      own_reg,     own_next;
  logic            out_bit_reg, out_bit_next;
  logic            scl_drv_reg, scl_drv_next;
  logic            sda_drv_reg, sda_drv_next;
  logic            scl_oe_reg,  scl_oe_next;
  logic            master_reg,  master_next;
  logic            tx_reg,      tx_next;
  logic            start_reg,   start_next;
  logic            stop_reg,    stop_next;
  logic            ack_request_flag_reg,   ack_request_flag_next;
  logic            arb_reg,     arb_next;
  logic            ack_reg,     ack_next;
  logic            si_reg,      si_next;
  logic            dwr_reg,     dwr_next;
  logic            slv_reg,     slv_next;
  logic            busy_reg,    busy_next;
  logic            first_reg,   first_next;
  logic [2:0]      wsel_reg,    wsel_next;
  logic [DW-1:0]   hrdata_reg,  hrdata_next;
  logic            acc;
  logic            sw_si_clr;
  logic            tdone;
  logic            tload;
  logic            lose;
  logic            own_gen;
  logic [7:0]      ctrl_vec;

  always_comb begin
    state_next   = state_reg;
    phase_next   = phase_reg;
    cnt_next     = cnt_reg;
    shift_next   = shift_reg;
    own_next     = own_reg;
    out_bit_next = out_bit_reg;
    scl_drv_next = scl_drv_reg;
    sda_drv_next = sda_drv_reg;
    master_next  = master_reg;
    tx_next      = tx_reg;
    start_next   = start_reg;
    stop_next    = stop_reg;
    ack_request_flag_next   = ack_request_flag_reg;
    arb_next     = arb_reg;
    ack_next     = ack_reg;
    si_next      = si_reg;
    dwr_next     = dwr_reg;
    slv_next     = slv_reg;
    busy_next    = busy_reg;
    first_next   = first_reg;
    lose         = 1'b0;
    tload        = 1'b0;
    tdone        = (timer_reg == 8'h00);
    acc          = i_hsel & i_htrans[1] & i_hready;
    sw_si_clr    = wsel_reg[0] & ~i_hwdata[B_SI] & si_reg;
    own_gen      = state_reg[1] | state_reg[4] | state_reg[5];

    // Data phase of a write lands here
    if (wsel_reg[0]) begin
      start_next = i_hwdata[B_START];
      stop_next  = i_hwdata[B_STOP];
      ack_next   = i_hwdata[B_ACK];
    end
    if (wsel_reg[1]) begin
      shift_next   = i_hwdata[7:0];
      out_bit_next = i_hwdata[7];
      dwr_next     = 1'b1;
    end
    if (wsel_reg[2]) begin
      own_next = i_hwdata[6:0];
    end
    if (sw_si_clr) begin
      si_next  = 1'b0;
      arb_next = 1'b0;
      tload    = 1'b1;
    end

    // Master SCL: low half, release, wait out stretching, high half
    if (master_reg & ~si_reg & (state_reg[2] | state_reg[3])) begin
      if (scl_drv_reg) begin
        if (tdone) begin
          scl_drv_next = 1'b0;
          tload        = 1'b1;
        end
      end else if (~lines.scl_s) begin
        tload = 1'b1;
      end else if (tdone) begin
        scl_drv_next = 1'b1;
        tload        = 1'b1;
      end
    end

    case (state_reg)
      ST_IDLE: begin
        sda_drv_next = 1'b0;
        scl_drv_next = 1'b0;
        if (start_reg & ~busy_reg) begin
          sda_drv_next = 1'b1;
          tload        = 1'b1;
          state_next   = ST_GSTART;
        end
      end
      ST_GSTART: begin
        if (tdone) begin
          scl_drv_next = 1'b1;
          master_next  = 1'b1;
          tx_next      = 1'b1;
          si_next      = 1'b1;
          dwr_next     = 1'b0;
          first_next   = 1'b0;
          cnt_next     = 4'h0;
          state_next   = ST_BYTE;
        end
      end
      ST_BYTE: begin
        if (lines.scl_rise) begin
          shift_next = {shift_reg[6:0], lines.sda_s};
          cnt_next   = cnt_reg + 4'h1;
          if (tx_reg & out_bit_reg & ~lines.sda_s) begin
            lose = 1'b1;
          end
        end
        if (lines.scl_fall & (cnt_reg == BYTE_BITS)) begin
          first_next = 1'b0;
          state_next = ST_ACK;
          if (first_reg & ~master_reg) begin
            if (shift_reg[7:1] == own_reg) begin
              slv_next   = 1'b1;
              start_next = 1'b1;
              si_next    = 1'b1;
              ack_request_flag_next = 1'b1;
            end else begin
              state_next = ST_IDLE;
            end
          end else if (~tx_reg) begin
            si_next    = 1'b1;
            ack_request_flag_next = 1'b1;
          end else begin
            sda_drv_next = 1'b0;
          end
        end else if (lines.scl_fall & tx_reg) begin
          out_bit_next = shift_reg[7];
        end
        // Transmit frame begins when software releases the byte event
        if (sw_si_clr & (cnt_reg == 4'h0)) begin
          if (master_reg & stop_next) begin
            state_next = ST_GSTOP;
            phase_next = PH_0;
          end else if (master_reg & start_next) begin
            state_next = ST_GRST;
            phase_next = PH_0;
          end else begin
            tx_next      = dwr_reg;
            dwr_next     = 1'b0;
            out_bit_next = shift_reg[7];
          end
        end
      end
      ST_ACK: begin
        if (lines.scl_rise & tx_reg) begin
          ack_next = ~lines.sda_s;
        end
        if (lines.scl_fall) begin
          ack_request_flag_next = 1'b0;
          cnt_next   = 4'h0;
          state_next = ST_BYTE;
          if (tx_reg) begin
            si_next = 1'b1;
            if (~master_reg & ~ack_next) begin
              state_next = ST_IDLE;
            end
          end else if (master_reg & stop_reg) begin
            state_next = ST_GSTOP;
            phase_next = PH_0;
          end else if (master_reg & start_reg) begin
            state_next = ST_GRST;
            phase_next = PH_0;
          end else if (~master_reg & ~ack_reg) begin
            state_next = ST_IDLE;
          end else begin
            tx_next      = dwr_reg;
            dwr_next     = 1'b0;
            out_bit_next = shift_reg[7];
          end
        end
      end
      ST_GSTOP: begin
        case (phase_reg)
          PH_0: begin
            sda_drv_next = 1'b1;
            if (tdone) begin
              scl_drv_next = 1'b0;
              tload        = 1'b1;
              phase_next   = PH_1;
            end
          end
          PH_1: begin
            if (tdone) begin
              if (~lines.scl_s) begin
                lose = 1'b1;
              end else begin
                sda_drv_next = 1'b0;
                tload        = 1'b1;
                phase_next   = PH_2;
              end
            end
          end
          default: begin
            if (tdone) begin
              stop_next   = 1'b0;
              master_next = 1'b0;
              state_next  = ST_IDLE;
            end
          end
        endcase
      end
      ST_GRST: begin
        case (phase_reg)
          PH_0: begin
            sda_drv_next = 1'b0;
            if (tdone) begin
              scl_drv_next = 1'b0;
              tload        = 1'b1;
              phase_next   = PH_1;
            end
          end
          PH_1: begin
            if (tdone) begin
              if (~lines.scl_s) begin
                lose = 1'b1;
              end else begin
                sda_drv_next = 1'b1;
                tload        = 1'b1;
                phase_next   = PH_2;
              end
            end
          end
          default: begin
            if (tdone) begin
              state_next = ST_GSTART;
            end
          end
        endcase
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase

    // Bus conditions from others outrank the sequencer
    if (lines.start_det) begin
      busy_next = 1'b1;
    end
    if (lines.stop_det) begin
      busy_next = 1'b0;
    end
    if (lines.start_det & ~own_gen) begin
      if (master_reg & ~start_reg) begin
        lose = 1'b1;
      end else begin
        tx_next      = 1'b0;
        slv_next     = 1'b0;
        first_next   = 1'b1;
        cnt_next     = 4'h0;
        sda_drv_next = 1'b0;
        state_next   = ST_BYTE;
      end
    end
    if (lines.stop_det & ~own_gen) begin
      if (slv_reg) begin
        stop_next = 1'b1;
        si_next   = 1'b1;
      end
      if (master_reg) begin
        stop_next = 1'b1;
        lose      = 1'b1;
      end
      slv_next   = 1'b0;
      state_next = ST_IDLE;
    end
    if (lose) begin
      arb_next     = 1'b1;
      master_next  = 1'b0;
      tx_next      = 1'b0;
      si_next      = 1'b1;
      sda_drv_next = 1'b0;
      scl_drv_next = 1'b0;
      state_next   = ST_IDLE;
    end

    // Hold SDA while the event stands so it never moves with SCL high
    if ((state_next == ST_BYTE) & ~si_next) begin
      sda_drv_next = tx_next & ~out_bit_next;
    end
    if ((state_next == ST_ACK) & ~tx_next) begin
      sda_drv_next = ~si_next & ack_next;
    end
    // Slave holds SCL a half period past the event so its ack bit settles before SCL rises
    scl_oe_next = scl_drv_next | (si_next & (state_next != ST_IDLE)) | (slv_next & (tload | ~tdone));

    timer_next = tload ? HALF_LOAD : (tdone ? timer_reg : timer_reg - 8'h01);
    wsel_next  = 3'h0;
    if (acc & i_hwrite) begin
      wsel_next = {f_hit(i_haddr, OFF_OWN), f_hit(i_haddr, OFF_DATA), f_hit(i_haddr, OFF_CTRL)};
    end
    ctrl_vec    = {master_next, tx_next, start_next, stop_next,
                   ack_request_flag_next, arb_next, ack_next, si_next};
    hrdata_next = hrdata_reg;
    if (acc & ~i_hwrite) begin
      hrdata_next = 32'h0000_0000;
      if (f_hit(i_haddr, OFF_CTRL)) begin
        hrdata_next = {24'h00_0000, ctrl_vec};
      end else if (f_hit(i_haddr, OFF_DATA)) begin
        hrdata_next = {24'h00_0000, shift_next};
      end else if (f_hit(i_haddr, OFF_OWN)) begin
        hrdata_next = {25'h000_0000, own_next};
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_reg   <= ST_IDLE;
      phase_reg   <= PH_0;
      timer_reg   <= 8'h00;
      cnt_reg     <= 4'h0;
      shift_reg   <= DATA_RST;
      own_reg     <= OWN_RST;
      out_bit_reg <= 1'b1;
      scl_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      scl_oe_reg  <= 1'b0;
      {master_reg, tx_reg, start_reg, stop_reg, ack_request_flag_reg, arb_reg, ack_reg, si_reg} <= CTRL_RST;
      dwr_reg     <= 1'b0;
      slv_reg     <= 1'b0;
      busy_reg    <= 1'b0;
      first_reg   <= 1'b0;
      wsel_reg    <= 3'h0;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      state_reg   <= state_next;
      phase_reg   <= phase_next;
      timer_reg   <= timer_next;
      cnt_reg     <= cnt_next;
      shift_reg   <= shift_next;
      own_reg     <= own_next;
      out_bit_reg <= out_bit_next;
      scl_drv_reg <= scl_drv_next;
      sda_drv_reg <= sda_drv_next;
      scl_oe_reg  <= scl_oe_next;
      {master_reg, tx_reg, start_reg, stop_reg, ack_request_flag_reg, arb_reg, ack_reg, si_reg} <= ctrl_vec;
      dwr_reg     <= dwr_next;
      slv_reg     <= slv_next;
      busy_reg    <= busy_next;
      first_reg   <= first_next;
      wsel_reg    <= wsel_next;
      hrdata_reg  <= hrdata_next;
    end
  end

  // Zero-wait slave; open-drain lines only ever pull low
  assign o_hrdata    = hrdata_reg;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_scl_out   = 1'b0;
  assign o_scl_oe    = scl_oe_reg;
  assign o_sda_out   = 1'b0;
  assign o_sda_oe    = sda_drv_reg;
endmodule : smbcs_top
`default_nettype wire

// ==== testbench/smbcs_properties.sv ====
// Concurrent checks on the top ports of the SMBus flag engine
`default_nettype none
module smbcs_properties
  import smbcs_pkg::*;
(
  input wire logic          i_mclk,
  input wire logic          i_srst,
  input wire logic          i_hsel,
  input wire logic [DW-1:0] i_haddr,
  input wire logic [1:0]    i_htrans,
  input wire logic          i_hwrite,
  input wire logic          i_hready,
  input wire logic          i_scl,
  input wire logic [DW-1:0] o_hrdata,
  input wire logic          o_hreadyout,
  input wire logic          o_hresp,
  input wire logic          o_scl_out,
  input wire logic          o_scl_oe,
  input wire logic          o_sda_out,
  input wire logic          o_sda_oe
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  AST_ALWAYS_OKAY: assert property (o_hreadyout && !o_hresp)
    else $error("slave stalled or answered with an error");
  AST_OPEN_DRAIN: assert property (!o_scl_out && !o_sda_out)
    else $error("pin driven to a high level");
  AST_RESET_OUT: assert property ($fell(i_srst) |-> !o_scl_oe && !o_sda_oe && o_hrdata == 32'h0)
    else $error("outputs not idle after reset");
  AST_UPPER_ZERO: assert property (o_hrdata[31:8] == 24'h0)
    else $error("read data has upper bits set");
  AST_HOLE_ZERO: assert property (i_hsel && i_htrans[1] && i_hready && !i_hwrite && i_haddr[31:2] > 30'h2
    |=> o_hrdata == 32'h0)
    else $error("unmapped read returned data");
  // A START made by the block is followed by its own SCL hold
  AST_START_SCL: assert property ($rose(o_sda_oe) && !o_scl_oe && i_scl |-> !o_scl_oe [*8] ##[1:400] o_scl_oe)
    else $error("no SCL hold after generated start");
  AST_SCL_LOW_MIN: assert property ($rose(o_scl_oe) |-> o_scl_oe [*8])
    else $error("SCL low phase too short");
  AST_SCL_HIGH_MIN: assert property ($fell(o_scl_oe) |-> !o_scl_oe [*8])
    else $error("SCL high phase too short");
endmodule : smbcs_properties

bind smbcs_top smbcs_properties smbcs_properties_inst (.i_mclk, .i_srst, .i_hsel, .i_haddr, .i_htrans,
  .i_hwrite, .i_hready, .i_scl, .o_hrdata, .o_hreadyout, .o_hresp, .o_scl_out, .o_scl_oe, .o_sda_out, .o_sda_oe);
`default_nettype wire

// ==== testbench/smbcs_slave_model.sv ====
// Behavioural SMBus slave that acknowledges writes to its own address
`default_nettype none
module smbcs_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_nack,
  output logic      o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bit_cnt = 0;
  logic       addr_ph = 1'b0;
  logic       sel     = 1'b0;
  logic [7:0] shift   = 8'h00;
  initial o_sda_oe = 1'b0;

  // START rearms the address match, STOP drops selection
  always @(negedge i_sda) if (i_scl) begin
    bit_cnt = 0;
    addr_ph = 1'b1;
    sel = 1'b0;
  end
  always @(posedge i_sda) if (i_scl) begin
    sel = 1'b0;
    addr_ph = 1'b0;
  end
  always @(posedge i_scl) begin
    if (bit_cnt < 8) shift = {shift[6:0], i_sda};
    bit_cnt = bit_cnt + 1;
  end
  // It answers with not-acknowledge when not selected, or when selected and the bench orders a refusal
  always @(negedge i_scl) begin
    if (bit_cnt == 8) begin
      if (addr_ph) sel = (shift[7:1] == ADDR) && !shift[0];
      o_sda_oe = sel && !i_nack;
    end else if (bit_cnt == 9) begin
      bit_cnt = 0;
      addr_ph = 1'b0;
      o_sda_oe = 1'b0;
    end
  end
endmodule : smbcs_slave_model
`default_nettype wire

// ==== testbench/smbcs_top_bench.sv ====
// Self-checking bench for the SMBus control and status flag engine
`default_nettype none
module smbcs_top_bench
  import smbcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] MDL_ADDR = 7'h2a;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready, hresp, scl_oe, sda_oe, mdl_oe, s;
  logic        bm_scl = 1'b0, bm_sda = 1'b0, force_low = 1'b0, nack = 1'b0;
  logic [31:0] rd;
  int          fails = 0;
  int          checks_done = 0;
  wire logic   scl_w = !(scl_oe | bm_scl);
  wire logic   sda_w = !(sda_oe | mdl_oe | bm_sda | force_low);

  smbcs_top smbcs_top_inst (.i_mclk(mclk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_scl(scl_w), .o_scl_out(), .o_scl_oe(scl_oe), .i_sda(sda_w),
    .o_sda_out(), .o_sda_oe(sda_oe));
  smbcs_slave_model #(.ADDR(MDL_ADDR)) smbcs_slave_model_inst (.i_scl(scl_w), .i_sda(sda_w), .i_nack(nack),
    .o_sda_oe(mdl_oe));

  initial forever #4 mclk = ~mclk;

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask : xfer

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rchk(input string nm, input logic [31:0] a, input logic [7:0] exp, input logic [7:0] msk);
    xfer(a, 1'b0, 32'h0);
    chk(nm, rd[7:0] & msk, exp);
  endtask : rchk

  // Polls a control bit; a stuck flag shows up in the following compare
  task automatic wait_bit(input int idx, input logic v);
    int n = 0;
    do begin
      xfer(OFF_CTRL, 1'b0, 32'h0);
      n++;
    end while (rd[idx] !== v && n < 3000);
  endtask : wait_bit

  task automatic half();
    repeat (5) @(posedge mclk);
  endtask : half

  // One bus clock as external master; waits out any stretch by the block
  task automatic bm_bit(input logic b, output logic smp);
    int n = 0;
    @(posedge mclk);
    bm_sda <= !b;
    half();
    bm_scl <= 1'b0;
    while (scl_w !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    half();
    smp = sda_w;
    bm_scl <= 1'b1;
  endtask : bm_bit

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (80000) @(posedge mclk);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    rchk("ctrl", OFF_CTRL, CTRL_RST, 8'hff);
    rchk("data", OFF_DATA, DATA_RST, 8'hff);
    rchk("own", OFF_OWN, {1'b0, OWN_RST}, 8'hff);
    rchk("hole", 32'h0000_000c, 8'h00, 8'hff);
    xfer(OFF_CTRL, 1'b1, 32'h0000_00cb);
    rchk("ctrl_ro", OFF_CTRL, 8'h02, 8'hff);
    xfer(OFF_CTRL, 1'b1, 32'h0);
    xfer(OFF_OWN, 1'b1, 32'h0000_00d5);
    rchk("own_rw", OFF_OWN, 8'h55, 8'hff);
    // Slave receive with the bench as external master
    bm_sda <= 1'b1;
    half();
    bm_scl <= 1'b1;
    for (int i = 7; i >= 0; i--) bm_bit(1'(8'haa >> i), s);
    wait_bit(B_SI, 1'b1);
    rchk("slv_addr", OFF_CTRL, 8'h29, 8'hfd);
    bm_scl <= 1'b0;
    repeat (12) @(posedge mclk);
    chk("scl_held", {7'h0, scl_w}, 8'h00);
    xfer(OFF_CTRL, 1'b1, 32'h0000_0002);
    bm_bit(1'b1, s);
    chk("ack_sent", {7'h0, s}, 8'h00);
    // Let the SCL fall pass the line synchroniser before reading
    repeat (6) @(posedge mclk);
    rchk("ack_request_flag_clr", OFF_CTRL, 8'h00, 8'hc8);
    bm_sda <= 1'b1;
    half();
    bm_scl <= 1'b0;
    half();
    half();
    bm_sda <= 1'b0;
    wait_bit(B_SI, 1'b1);
    rchk("slv_stop", OFF_CTRL, 8'h11, 8'h11);
    xfer(OFF_CTRL, 1'b1, 32'h0);
    // Master transmitter against the slave model
    xfer(OFF_CTRL, 1'b1, 32'h0000_0020);
    wait_bit(B_SI, 1'b1);
    rchk("m_start", OFF_CTRL, 8'he1, 8'hff);
    xfer(OFF_DATA, 1'b1, {24'h0, MDL_ADDR, 1'b0});
    xfer(OFF_CTRL, 1'b1, 32'h0);
    wait_bit(B_SI, 1'b1);
    rchk("m_addr_ack", OFF_CTRL, 8'hc3, 8'hff);
    nack <= 1'b1;
    xfer(OFF_DATA, 1'b1, 32'h0000_005a);
    xfer(OFF_CTRL, 1'b1, 32'h0);
    wait_bit(B_SI, 1'b1);
    rchk("m_data_nack", OFF_CTRL, 8'hc1, 8'hff);
    nack <= 1'b0;
    xfer(OFF_CTRL, 1'b1, 32'h0000_0010);
    wait_bit(7, 1'b0);
    rchk("m_stop", OFF_CTRL, 8'h00, 8'hb0);
    // Arbitration lost on a one driven while SDA is held low
    xfer(OFF_CTRL, 1'b1, 32'h0000_0020);
    wait_bit(B_SI, 1'b1);
    xfer(OFF_DATA, 1'b1, 32'h0000_00ff);
    xfer(OFF_CTRL, 1'b1, 32'h0);
    repeat (60) @(posedge mclk);
    force_low <= 1'b1;
    wait_bit(B_SI, 1'b1);
    rchk("arb_lost", OFF_CTRL, 8'h05, 8'hc5);
    xfer(OFF_CTRL, 1'b1, 32'h0);
    rchk("arb_clr", OFF_CTRL, 8'h00, 8'h05);
    force_low <= 1'b0;
    repeat (200) @(posedge mclk);
    wrap_up();
  end
endmodule : smbcs_top_bench
`default_nettype wire
